// ### design/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Avalon-MM slave)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_SELECT = 5'h00;
    localparam logic [4:0] OFS_CTRL = 5'h04;
    localparam logic [4:0] OFS_RES_LO = 5'h08;
    localparam logic [4:0] OFS_RES_HI = 5'h0c;
    localparam logic [4:0] OFS_MODE = 5'h10;

    // Field positions.
    localparam int SEL_REF = 6;
    localparam int SEL_LEFT = 5;
    localparam int SEL_CH_LSB = 0;
    localparam int CS_ENABLE = 7;
    localparam int CS_START = 6;
    localparam int CS_AUTO = 5;
    localparam int CS_FLAG = 4;
    localparam int CS_IE = 3;
    localparam int CS_PS_LSB = 0;
    localparam int MODE_FREE = 0;

    // Reset values.
    localparam logic [2:0] PRESC_RESET = 3'h0;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // Conversion timing in converter clock cycles.
    localparam logic [4:0] CYC_NORMAL = 5'h0d;
    localparam logic [4:0] CYC_FIRST = 5'h19;
    localparam logic [4:0] SH_NORMAL = 5'h01;
    localparam logic [4:0] SH_FIRST = 5'h0d;

    // Code limits.
    localparam logic [9:0] FULL_SCALE = 10'h3ff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic reference_select;
        logic [1:0] channel_select;
    } select_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_CONVERT} conv_state_t;

endpackage : adc_ctrl_pkg

// ### design/adc_prescaler.sv
`timescale 1ns/1ps
module adc_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] div_sel,
    output logic tick
);

    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [6:0] last_count;

    // Division factor minus one; selections 0 and 1 both divide by two.
    function automatic logic [6:0] div_last(input logic [2:0] sel);
        logic [7:0] f;
        f = 8'h01 << ((sel == 3'h0) ? 3'h1 : sel);
        div_last = f[6:0] - 7'h01;
    endfunction : div_last

    assign last_count = div_last(div_sel);
    assign tick = run && !restart && (cnt_reg >= last_count);
    assign cnt_next = tick ? 7'h00 : cnt_reg + 7'h01;

    // Held in reset while the converter is off or a trigger realigns it.
    always_ff @(posedge clk) begin
        if (!rst_n || !run || restart) begin
            cnt_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : adc_prescaler

// ### design/adc_select_sleep_result_ctrl.sv
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Selection holding register always accessible; copied to active selection when idle.
// - Active selection frozen from conversion start.
// - Copying resumes in the last converter cycle before the done flag.
// - Start bit write begins conversion on the next converter clock edge.
// - A safely made selection change applies to the next conversion.
// - Free running: change after a completion affects only later conversions.
// - Reference select picks supply or internal 1.1V reference.
// - Inputs above the reference give codes at full scale 0x3FF.
// - Qualifying sleep entry starts a conversion once the CPU halts.
// - Completion interrupt request raised even if another interrupt woke the CPU.
// - Converter is never switched off automatically by sleep.
// - Result bytes are written by the time the done flag is set.
// - Code is Vin times 1024 over reference, 0x000 ground.
// - Start bit reads one during conversion, cleared at single-mode completion.
// - Normal conversion 13 converter cycles, first after enable 25.
// - Done flag set on completion; cleared by writing one or vector entry.
// - Low byte read blocks result updates until high byte read.
module adc_select_sleep_result_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [4:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [3:0] BYTEENABLE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic [9:0] CONV_CODE,
    input wire logic CONV_OVER,
    input wire logic AUTO_TRIGGER,
    input wire logic SLEEP_HALTED,
    input wire logic IRQ_ACK,
    output logic IRQ_REQ,
    output logic ANALOG_ON,
    output logic [1:0] ACTIVE_CHANNEL,
    output logic ACTIVE_REFERENCE,
    output logic SAMPLE_HOLD,
    output logic CONV_BUSY
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    select_t sel_hold_reg, active_sel_reg;
    logic left_reg, enable_reg, auto_reg, ie_reg, flag_reg, free_reg;
    logic [2:0] presc_reg;
    conv_state_t state_reg, state_next;
    logic [4:0] cyc_reg, cyc_next;
    logic first_reg, lock_reg, ack_reg, trig_prev_reg, sample_reg;
    logic [9:0] res_reg;
    logic [31:0] rdata_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req = READ || WRITE;
    wire accept = req && ack_reg;
    wire wr = accept && WRITE && BYTEENABLE[0];
    wire rd = accept && READ;
    wire wr_sel = wr && (ADDRESS == OFS_SELECT);
    wire wr_ctrl = wr && (ADDRESS == OFS_CTRL);
    wire wr_mode = wr && (ADDRESS == OFS_MODE);
    wire rd_lo = rd && (ADDRESS == OFS_RES_LO);
    wire rd_hi = rd && (ADDRESS == OFS_RES_HI);
    wire [7:0] wd = WRITEDATA[7:0];
    wire enable_next = wr_ctrl ? wd[CS_ENABLE] : enable_reg;

    // One wait state, so read data is registered before the accepting edge.
    assign WAITREQUEST = req && !ack_reg;

    // ------------------------------------------------------------
    // Analog-side inputs and converter clock
    // ------------------------------------------------------------
    logic [10:0] analog_s;
    logic tick;

    adc_sync2 #(.WIDTH(11)) u_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .d({CONV_OVER, CONV_CODE}),
        .q(analog_s)
    );

    wire trig_rise = AUTO_TRIGGER && !trig_prev_reg;
    wire idle = (state_reg == ST_IDLE);
    wire trig_start = trig_rise && auto_reg && enable_reg && idle;

    adc_prescaler u_presc (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .run(enable_reg),
        .restart(trig_start),
        .div_sel(presc_reg),
        .tick(tick)
    );

    // Over-range inputs saturate at full scale; otherwise the front end's
    // code Vin*1024/Vref is passed through, 0x000 being ground.
    wire [9:0] code_word = analog_s[10] ? FULL_SCALE : analog_s[9:0];

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    wire [4:0] conv_len = first_reg ? CYC_FIRST : CYC_NORMAL;
    wire [4:0] sh_cyc = first_reg ? SH_FIRST : SH_NORMAL;
    wire in_conv = (state_reg == ST_CONVERT);
    wire last_cycle = in_conv && (cyc_reg == conv_len - 5'h01);
    wire done = last_cycle && tick;
    wire sw_start = wr_ctrl && wd[CS_START] && wd[CS_ENABLE];
    // Sleep pulse from the power manager; software owns the preconditions.
    wire sleep_start = SLEEP_HALTED && enable_reg;
    wire start_evt = sw_start || sleep_start || trig_start;

    // Start is taken only when idle; a zero written to the start bit does nothing.
    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_evt) begin
                    state_next = ST_WAIT_EDGE;
                end
            end
            ST_WAIT_EDGE: begin
                if (tick) begin
                    state_next = ST_CONVERT;
                    cyc_next = 5'h00;
                end
            end
            ST_CONVERT: begin
                if (done) begin
                    state_next = free_reg ? ST_CONVERT : ST_IDLE;
                    cyc_next = 5'h00;
                end else if (tick) begin
                    cyc_next = cyc_reg + 5'h01;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Turning the converter off aborts; sleep never clears enable.
        if (!enable_next) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            cyc_reg <= 5'h00;
            first_reg <= 1'b1;
            trig_prev_reg <= 1'b0;
            sample_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            first_reg <= !enable_reg || (first_reg && !done);
            trig_prev_reg <= AUTO_TRIGGER;
            sample_reg <= in_conv && tick && (cyc_reg == sh_cyc - 5'h01);
        end
    end

    // ------------------------------------------------------------
    // Channel and reference selection
    // ------------------------------------------------------------
    // Outside a conversion, and again in its last cycle, the held selection
    // flows through; the frozen window protects the sampling time.
    wire copy_en = !in_conv || last_cycle;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sel_hold_reg <= '0;
            active_sel_reg <= '0;
            left_reg <= 1'b0;
        end else begin
            if (wr_sel) begin
                sel_hold_reg <= {wd[SEL_REF], wd[SEL_CH_LSB +: 2]};
                left_reg <= wd[SEL_LEFT];
            end
            if (copy_en) begin
                active_sel_reg <= sel_hold_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Control, flag and result
    // ------------------------------------------------------------
    // The completion set wins over a simultaneous clear.
    wire flag_clr = (wr_ctrl && wd[CS_FLAG]) || IRQ_ACK;
    wire flag_next = done || (flag_reg && !flag_clr);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            enable_reg <= 1'b0;
            auto_reg <= 1'b0;
            ie_reg <= 1'b0;
            presc_reg <= PRESC_RESET;
            free_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                enable_reg <= wd[CS_ENABLE];
                auto_reg <= wd[CS_AUTO];
                ie_reg <= wd[CS_IE];
                presc_reg <= wd[CS_PS_LSB +: 3];
            end
            if (wr_mode) begin
                free_reg <= wd[MODE_FREE];
            end
            flag_reg <= flag_next;
        end
    end

    // A completion while the low byte is pending loses its result but still
    // sets the flag, so software sees the overrun only as a stale pair.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            res_reg <= RESULT_RESET;
            lock_reg <= 1'b0;
        end else begin
            if (done && !lock_reg) begin
                res_reg <= code_word;
            end
            if (rd_lo) begin
                lock_reg <= 1'b1;
            end else if (rd_hi) begin
                lock_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data and handshake
    // ------------------------------------------------------------
    wire [7:0] res_lo = left_reg ? {res_reg[1:0], 6'h00} : res_reg[7:0];
    wire [7:0] res_hi = left_reg ? res_reg[9:2] : {6'h00, res_reg[9:8]};
    wire [7:0] sel_rd = {1'b0, sel_hold_reg.reference_select, left_reg, 3'h0,
                         sel_hold_reg.channel_select};
    wire [7:0] ctrl_rd = {enable_reg, !idle, auto_reg, flag_reg, ie_reg, presc_reg};
    logic [7:0] rd_mux;

    always_comb begin
        case (ADDRESS)
            OFS_SELECT: rd_mux = sel_rd;
            OFS_CTRL: rd_mux = ctrl_rd;
            OFS_RES_LO: rd_mux = res_lo;
            OFS_RES_HI: rd_mux = res_hi;
            OFS_MODE: rd_mux = {7'h00, free_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg) begin
                rdata_reg <= {24'h00_0000, rd_mux};
            end
        end
    end

    assign READDATA = rdata_reg;
    // The request stays up after a wake by another source.
    assign IRQ_REQ = flag_reg && ie_reg;
    assign ANALOG_ON = enable_reg;
    assign ACTIVE_CHANNEL = active_sel_reg.channel_select;
    assign ACTIVE_REFERENCE = active_sel_reg.reference_select;
    assign SAMPLE_HOLD = sample_reg;
    assign CONV_BUSY = !idle;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_done;
        done;
    endsequence

    sequence s_start_edge;
        (state_reg == ST_WAIT_EDGE) && tick && enable_next;
    endsequence

    a_start_on_edge: assert property (s_start_edge |=> in_conv && cyc_reg == 5'h00)
        else $error("conversion did not start on converter edge");
    a_select_frozen: assert property (in_conv && !last_cycle |=> $stable(active_sel_reg))
        else $error("active selection moved during conversion");
    a_copy_idle: assert property (idle |=> active_sel_reg == $past(sel_hold_reg))
        else $error("idle selection not copied");
    a_copy_last: assert property (last_cycle |=> active_sel_reg == $past(sel_hold_reg))
        else $error("last cycle did not copy selection");
    a_flag_done: assert property (s_done |=> flag_reg)
        else $error("done flag not set at completion");
    a_single_ends: assert property (s_done ##0 !free_reg ##0 enable_next |=> idle)
        else $error("single conversion did not return idle");
    a_free_restart: assert property (s_done ##0 free_reg ##0 enable_next
        |=> in_conv && cyc_reg == 5'h00 && !first_reg)
        else $error("free running did not restart");
    a_len_normal: assert property (in_conv && !first_reg |-> cyc_reg < CYC_NORMAL)
        else $error("normal conversion too long");
    a_len_first: assert property (in_conv && first_reg |-> cyc_reg < CYC_FIRST)
        else $error("first conversion too long");
    a_result_load: assert property (s_done ##0 !lock_reg |=> res_reg == $past(code_word))
        else $error("result not loaded at completion");
    a_result_lock: assert property (s_done ##0 lock_reg |=> $stable(res_reg))
        else $error("locked result was overwritten");
    a_sleep_start: assert property (SLEEP_HALTED && enable_reg && idle && enable_next
        |=> state_reg == ST_WAIT_EDGE)
        else $error("sleep halt did not start conversion");

endmodule : adc_select_sleep_result_ctrl

// ### design/adc_sync2.sv
`timescale 1ns/1ps
module adc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // Two stages; only the second stage reads the first.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : adc_sync2

// ### verif/afe_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Analog front end model
// ------------------------------------------------------------
module afe_model (
    input wire logic clk,
    input wire logic sample,
    input wire logic [1:0] channel,
    input wire logic reference,
    output logic [9:0] code,
    output logic over
);
    // Fixed pin voltages in millivolts; the last one lies above the internal reference.
    int vin_mv [4] = '{200, 500, 800, 1500};

    // Full scale is the supply or the internal reference.
    function automatic int vref_mv(input logic sel);
        return sel ? 1100 : 3300;
    endfunction : vref_mv

    initial begin
        code = 10'h000;
        over = 1'b0;
    end

    // The code is held from one sample to the next, so a late capture still sees it.
    always @(posedge clk) begin
        if (sample) begin
            over <= vin_mv[channel] >= vref_mv(reference);
            code <= 10'(vin_mv[channel] * 1024 / vref_mv(reference));
        end
    end
endmodule : afe_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import adc_ctrl_pkg::*;
    logic CORE_CLK = 1'b0, RST_N = 1'b0, READ = 1'b0, WRITE = 1'b0;
    logic AUTO_TRIGGER = 1'b0, SLEEP_HALTED = 1'b0, IRQ_ACK = 1'b0;
    logic [4:0] ADDRESS = 5'h00;
    logic [3:0] BYTEENABLE = 4'hf;
    logic [31:0] WRITEDATA = 32'h00000000;
    logic [31:0] READDATA, rd;
    logic WAITREQUEST, CONV_OVER, IRQ_REQ, ANALOG_ON, ACTIVE_REFERENCE, SAMPLE_HOLD, CONV_BUSY;
    logic [9:0] CONV_CODE;
    logic [1:0] ACTIVE_CHANNEL;
    int n_mismatch = 0;
    int n_checks = 0;
    int n;

    always #20 CORE_CLK = ~CORE_CLK;

    adc_select_sleep_result_ctrl DUT (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
        .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CONV_CODE(CONV_CODE),
        .CONV_OVER(CONV_OVER), .AUTO_TRIGGER(AUTO_TRIGGER), .SLEEP_HALTED(SLEEP_HALTED),
        .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .ANALOG_ON(ANALOG_ON),
        .ACTIVE_CHANNEL(ACTIVE_CHANNEL), .ACTIVE_REFERENCE(ACTIVE_REFERENCE),
        .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_BUSY(CONV_BUSY));

    afe_model AFE (.clk(CORE_CLK), .sample(SAMPLE_HOLD), .channel(ACTIVE_CHANNEL),
        .reference(ACTIVE_REFERENCE), .code(CONV_CODE), .over(CONV_OVER));

    // ------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One Avalon transfer; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int k;
        k = 0;
        ADDRESS <= a;
        WRITE <= wr;
        READ <= !wr;
        WRITEDATA <= {24'h000000, d};
        do begin
            @(posedge CORE_CLK);
            k++;
        end while (WAITREQUEST !== 1'b0 && k < 20);
        q = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
        @(posedge CORE_CLK);
        if (k >= 20) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h000000, exp});
    endtask : rdc

    // Waits for the end of a conversion, or for the interrupt request.
    task automatic wait_for(input bit use_irq, output int k);
        k = 0;
        do begin
            @(posedge CORE_CLK);
            k++;
        end while ((use_irq ? IRQ_REQ : !CONV_BUSY) !== 1'b1 && k < 200);
        if (k >= 200) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_for

    task automatic pulse(input bit sleep);
        if (sleep) SLEEP_HALTED <= 1'b1;
        else IRQ_ACK <= 1'b1;
        @(posedge CORE_CLK);
        SLEEP_HALTED <= 1'b0;
        IRQ_ACK <= 1'b0;
        @(posedge CORE_CLK);
    endtask : pulse

    // The expected code is worked out from the pin voltage, independent of the model.
    function automatic logic [9:0] ecode(input int ch, input int rf);
        int v [4] = '{200, 500, 800, 1500};
        int r = rf ? 1100 : 3300;
        if (v[ch] >= r) return 10'h3ff;
        return 10'(v[ch] * 1024 / r);
    endfunction : ecode

    task automatic chk_res(input int ch, input int rf);
        logic [9:0] e;
        e = ecode(ch, rf);
        rdc(OFS_RES_LO, e[7:0]);
        rdc(OFS_RES_HI, {6'h00, e[9:8]});
    endtask : chk_res

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        @(posedge CORE_CLK);
        rdc(OFS_CTRL, 8'h00);
        rdc(OFS_RES_LO, 8'h00);
        // The low-byte read locks the result pair; the high-byte read releases it again.
        rdc(OFS_RES_HI, 8'h00);
        wr(5'h14, 8'hff);
        rdc(5'h14, 8'h00);
        BYTEENABLE <= 4'h0;
        wr(OFS_SELECT, 8'h41);
        BYTEENABLE <= 4'hf;
        rdc(OFS_SELECT, 8'h00);
        wr(OFS_SELECT, 8'h42);
        rdc(OFS_SELECT, 8'h42);
        chk(32'(ACTIVE_CHANNEL), 32'h2);
        chk(32'(ACTIVE_REFERENCE), 32'h1);
        wr(OFS_CTRL, 8'hc0);
        wait_for(0, n);
        chk(32'(n >= 47 && n <= 54), 32'h1);
        rdc(OFS_CTRL, 8'h90);
        chk_res(2, 1);
        wr(OFS_CTRL, 8'h90);
        rdc(OFS_CTRL, 8'h80);
        wr(OFS_CTRL, 8'hc0);
        wr(OFS_SELECT, 8'h01);
        chk(32'(ACTIVE_CHANNEL), 32'h2);
        rdc(OFS_CTRL, 8'hc0);
        wait_for(0, n);
        chk(32'(ACTIVE_CHANNEL), 32'h1);
        chk_res(2, 1);
        wr(OFS_CTRL, 8'hd0);
        wait_for(0, n);
        chk(32'(n >= 23 && n <= 30), 32'h1);
        chk_res(1, 0);
        // A low-byte read before the next conversion must keep the old result.
        // The first result after this reference switch is thrown away by the lock.
        wr(OFS_SELECT, 8'h43);
        bus(1'b0, OFS_RES_LO, 8'h00, rd);
        wr(OFS_CTRL, 8'hd0);
        wait_for(0, n);
        rdc(OFS_CTRL, 8'h90);
        chk_res(1, 0);
        wr(OFS_CTRL, 8'hd0);
        wait_for(0, n);
        chk_res(3, 1);
        // Free running with a channel change after the first completion.
        wr(OFS_SELECT, 8'h00);
        wr(OFS_MODE, 8'h01);
        wr(OFS_CTRL, 8'hd8);
        wait_for(1, n);
        wr(OFS_SELECT, 8'h03);
        pulse(0);
        chk(32'(IRQ_REQ), 32'h0);
        wait_for(1, n);
        rdc(OFS_CTRL, 8'hd8);
        chk_res(0, 0);
        pulse(0);
        wait_for(1, n);
        chk_res(3, 0);
        wr(OFS_MODE, 8'h00);
        wr(OFS_CTRL, 8'h10);
        repeat (2) @(posedge CORE_CLK);
        chk(32'(ANALOG_ON), 32'h0);
        chk(32'(CONV_BUSY), 32'h0);
        // Sleep start from an enabled, idle, single-mode converter.
        wr(OFS_CTRL, 8'h88);
        pulse(1);
        chk(32'(CONV_BUSY), 32'h1);
        wait_for(1, n);
        chk(32'(ANALOG_ON), 32'h1);
        rdc(OFS_CTRL, 8'h98);
        chk_res(3, 0);
        // Auto trigger, selection changed while triggering is still off.
        wr(OFS_SELECT, 8'h01);
        wr(OFS_CTRL, 8'hb8);
        AUTO_TRIGGER <= 1'b1;
        wait_for(1, n);
        AUTO_TRIGGER <= 1'b0;
        chk_res(1, 0);
        // Left adjustment reshapes the stored result at read time only.
        wr(OFS_SELECT, 8'h21);
        rdc(OFS_SELECT, 8'h21);
        rdc(OFS_RES_LO, 8'(ecode(1, 0) << 6));
        rdc(OFS_RES_HI, 8'(ecode(1, 0) >> 2));
        give_verdict();
    end
endmodule : tb_top
